// ### include/apsr_params.svh
// Notes on behaviour
// (RULE1) Read uses command 02, data number 91
// (RULE2) Reply carries 32-bit hex position
// (RULE3) Read addressed to chosen drive station
// (RULE4) Drive returns current position as reply
// (RULE5) Drive loads reply into position command
// (RULE6) Read position after every servo-on assertion
// (RULE7) Controller watches transfer for time-outs
// (RULE8) Power stage on 95 ms after servo-on
// (RULE9) Ready only after power stage enabled
// (RULE10) No pulses before ready and position
// (RULE11) Drive answers faults with error code
// (RULE12) Retry errors, then enter error handling
// (RULE13) On alarm, drop servo-on first
// (RULE14) After alarm clear, redo full sequence
// (RULE15) Stop release: 210 ms stage, 5 ms ready
// (RULE16) Read between ready and first pulse
// (RULE17) Read each time ready rises
// (RULE18) Missing or bad reply counts as error
`ifndef APSR_PARAMS_SVH
`define APSR_PARAMS_SVH
`define APSR_CMD_READ       8'h02
`define APSR_DATA_ABS       8'h91
`define APSR_CLK_HZ         25000000
`define APSR_TIMEOUT_MS     100
`define APSR_TIMEOUT_CYC    ((`APSR_CLK_HZ / 1000) * `APSR_TIMEOUT_MS)
`define APSR_RETRIES        3
`define APSR_ADDR_CTRL      4'h0
`define APSR_ADDR_STATUS    4'h1
`define APSR_ADDR_POS       4'h2
`define APSR_ADDR_IRQ_STAT  4'h3
`define APSR_ADDR_IRQ_EN    4'h4
`define APSR_ADDR_IRQ_CLR   4'h5
`define APSR_CTRL_SERVO     0
`define APSR_CTRL_RESET     1
`define APSR_CTRL_STATION   8
`define APSR_EV_DONE        0
`define APSR_EV_FAIL        1
`define APSR_EV_ALARM       2
`define APSR_EV_W           3
`endif

// ### include/apsr_pkg.sv
package apsr_pkg;
	typedef enum logic [6:0] {
		APSR_IDLE  = 7'h01,
		APSR_WAIT  = 7'h02,
		APSR_SEND  = 7'h04,
		APSR_RECV  = 7'h08,
		APSR_RUN   = 7'h10,
		APSR_FAIL  = 7'h20,
		APSR_ALARM = 7'h40
	} apsr_state_e;
	typedef logic [31:0] apsr_pos_t;
endpackage : apsr_pkg

// ### rtl/apsr_timer.sv
`timescale 1ns/10ps
`default_nettype none
module apsr_timer #(
	parameter int W = 32
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic [W-1:0] limit,
	output logic              expired
);
	logic [W-1:0] count;
	logic         running;
	// Time-out watch on a pending reply
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			running <= 1'b0;
			count   <= '0;
		end else if (start) begin
			// Start wins: the command is taken before the receive state (APSR_RECV) is entered
			running <= 1'b1;
			count   <= '0;
		end else if (stop) begin
			running <= 1'b0;
			count   <= '0;
		end else if (running && count != limit) begin
			count <= count + 1'b1;
		end
	end
	assign expired = running && (count == limit);
endmodule : apsr_timer
`default_nettype wire

// ### rtl/apsr_irq.sv
`timescale 1ns/10ps
`default_nettype none
module apsr_irq #(
	parameter int N = 3
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic [N-1:0] events,
	input  wire logic [N-1:0] clear,
	input  wire logic         en_we,
	input  wire logic [N-1:0] en_wdata,
	output logic      [N-1:0] status,
	output logic      [N-1:0] enable,
	output logic              irq
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			// Set wins over clear
			always_ff @(posedge clock) begin
				if (!rst_b) begin
					status[i] <= 1'b0;
				end else if (events[i]) begin
					status[i] <= 1'b1;
				end else if (clear[i]) begin
					status[i] <= 1'b0;
				end
			end
		end
	endgenerate
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			enable <= '0;
		end else if (en_we) begin
			enable <= en_wdata;
		end
	end
	assign irq = |(status & enable);
endmodule : apsr_irq
`default_nettype wire

// ### rtl/apsr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "apsr_params.svh"
module apsr_ctrl #(
	parameter int TIMEOUT_CYC = `APSR_TIMEOUT_CYC,
	parameter int RETRIES     = `APSR_RETRIES
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	output logic             servo_on_input,
	output logic             alarm_reset_input,
	input  wire logic        ready_output,
	input  wire logic        trouble_output,
	input  wire logic        forced_stop_input,
	output logic             cmd_valid,
	output logic      [7:0]  cmd_station,
	output logic      [7:0]  cmd_code,
	output logic      [7:0]  cmd_data_no,
	input  wire logic        cmd_ready,
	input  wire logic        reply_valid,
	input  wire logic        reply_error,
	input  wire logic [31:0] reply_pos,
	output logic             pulse_enable,
	output logic             irq
);
	apsr_pkg::apsr_state_e state;
	apsr_pkg::apsr_state_e next_state;
	apsr_pkg::apsr_pos_t   position;
	logic                  servo_req;
	logic [7:0]            station;
	logic                  ready_q;
	logic                  ready_rise;
	logic [7:0]            tries;
	logic                  expired;
	logic                  got_good;
	logic                  got_bad;
	logic [`APSR_EV_W-1:0] events;
	logic [`APSR_EV_W-1:0] irq_status;
	logic [`APSR_EV_W-1:0] irq_enable;
	logic                  alarm_q;
	logic                  rst_pulse;

	assign ready_rise = ready_output && !ready_q;
	assign got_good   = (state == apsr_pkg::APSR_RECV) && reply_valid && !reply_error;
	assign got_bad    = (state == apsr_pkg::APSR_RECV) && ((reply_valid && reply_error) || expired); // [RULE11] [RULE18]

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ready_q <= 1'b0;
			alarm_q <= 1'b0;
		end else begin
			ready_q <= ready_output;
			alarm_q <= trouble_output;
		end
	end

	// Servo-on drive; alarm forces it low
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			servo_req <= 1'b0;
			station   <= 8'h00;
			rst_pulse <= 1'b0;
		end else begin
			rst_pulse <= 1'b0;
			if (trouble_output) begin
				servo_req <= 1'b0; // [RULE13]
			end else if (wr && addr == `APSR_ADDR_CTRL) begin
				servo_req <= wdata[`APSR_CTRL_SERVO];
				station   <= wdata[`APSR_CTRL_STATION +: 8];
				rst_pulse <= wdata[`APSR_CTRL_RESET];
			end
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			servo_on_input    <= 1'b0;
			alarm_reset_input <= 1'b0;
		end else begin
			servo_on_input    <= servo_req && !trouble_output;
			alarm_reset_input <= rst_pulse && !servo_req;
		end
	end

	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			apsr_pkg::APSR_IDLE: begin
				if (servo_on_input) begin
					next_state = apsr_pkg::APSR_WAIT; // [RULE6]
				end
			end
			apsr_pkg::APSR_WAIT: begin
				if (ready_rise) begin
					next_state = apsr_pkg::APSR_SEND; // [RULE17] [RULE9] [RULE8] [RULE15]
				end
			end
			apsr_pkg::APSR_SEND: begin
				if (cmd_ready) begin
					next_state = apsr_pkg::APSR_RECV;
				end
			end
			apsr_pkg::APSR_RECV: begin
				if (got_good) begin
					next_state = apsr_pkg::APSR_RUN;
				end else if (got_bad) begin
					next_state = (tries >= 8'(RETRIES)) ? apsr_pkg::APSR_FAIL : apsr_pkg::APSR_SEND; // [RULE12]
				end
			end
			apsr_pkg::APSR_RUN: begin
				if (!ready_output) begin
					next_state = apsr_pkg::APSR_WAIT; // [RULE17]
				end
			end
			apsr_pkg::APSR_FAIL: begin
				if (!servo_on_input) begin
					next_state = apsr_pkg::APSR_IDLE;
				end
			end
			apsr_pkg::APSR_ALARM: begin
				if (!trouble_output && !servo_on_input) begin
					next_state = apsr_pkg::APSR_IDLE; // [RULE14]
				end
			end
			default: next_state = apsr_pkg::APSR_IDLE;
		endcase
		if (trouble_output) begin
			next_state = apsr_pkg::APSR_ALARM; // [RULE13]
		end else if (!servo_on_input && state != apsr_pkg::APSR_ALARM) begin
			next_state = apsr_pkg::APSR_IDLE;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state <= apsr_pkg::APSR_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tries <= 8'h00;
		end else if (state == apsr_pkg::APSR_WAIT) begin
			tries <= 8'h00;
		end else if (got_bad) begin
			tries <= tries + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			position <= '0;
		end else if (got_good) begin
			position <= reply_pos; // [RULE2]
		end
	end

	// Command fields
	assign cmd_valid   = (state == apsr_pkg::APSR_SEND);
	assign cmd_station = station;       // [RULE3]
	assign cmd_code    = `APSR_CMD_READ; // [RULE1]
	assign cmd_data_no = `APSR_DATA_ABS; // [RULE1]

	// Pulses only after a fresh position
	assign pulse_enable = (state == apsr_pkg::APSR_RUN) && ready_output; // [RULE10] [RULE16]

	apsr_timer #(
		.W(32)
	) u_timer (
		.clock  (clock),
		.rst_b  (rst_b),
		.start  (cmd_valid && cmd_ready),
		.stop   (state != apsr_pkg::APSR_RECV || reply_valid),
		.limit  (32'(TIMEOUT_CYC)),
		.expired(expired) // [RULE7]
	);

	assign events = {trouble_output && !alarm_q,
	                 got_bad && tries >= 8'(RETRIES),
	                 got_good};

	apsr_irq #(
		.N(`APSR_EV_W)
	) u_irq (
		.clock   (clock),
		.rst_b   (rst_b),
		.events  (events),
		.clear   ((wr && addr == `APSR_ADDR_IRQ_CLR) ? wdata[`APSR_EV_W-1:0] : '0),
		.en_we   (wr && addr == `APSR_ADDR_IRQ_EN),
		.en_wdata(wdata[`APSR_EV_W-1:0]),
		.status  (irq_status),
		.enable  (irq_enable),
		.irq     (irq)
	);

	// Register read, data one cycle later
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			if (addr == `APSR_ADDR_CTRL) begin
				rdata <= {16'h0000, station, 7'h00, servo_req};
			end else if (addr == `APSR_ADDR_STATUS) begin
				rdata <= {8'h00, tries, 5'h00, forced_stop_input, trouble_output, ready_output, 1'b0, state};
			end else if (addr == `APSR_ADDR_POS) begin
				rdata <= position;
			end else if (addr == `APSR_ADDR_IRQ_STAT) begin
				rdata <= {29'h0, irq_status};
			end else if (addr == `APSR_ADDR_IRQ_EN) begin
				rdata <= {29'h0, irq_enable};
			end else begin
				rdata <= 32'h0000_0000;
			end
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule : apsr_ctrl
`default_nettype wire

// ### tb/apsr_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module apsr_ctrl_properties (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic       servo_on_input,
	input wire logic       ready_output,
	input wire logic       trouble_output,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic [7:0] cmd_station,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_data_no,
	input wire logic       reply_valid,
	input wire logic       reply_error,
	input wire logic       pulse_enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	read_code_a: assert property (cmd_valid |-> cmd_code == 8'h02 && cmd_data_no == 8'h91)
		else $error("code");
	cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_station))
		else $error("hold");
	servo_read_a: assert property (cmd_valid |-> servo_on_input) else $error("servo");
	pulse_gate_a: assert property (pulse_enable |-> ready_output) else $error("gate");
	error_hold_a: assert property (reply_valid && reply_error |=> !pulse_enable) else $error("err");
	alarm_drop_a: assert property (trouble_output |=> !servo_on_input) else $error("alarm");
	run_cause_a: assert property ($rose(pulse_enable) |-> $past(reply_valid && !reply_error))
		else $error("run");
	ready_read_a: assert property ($rose(ready_output) && servo_on_input |=> cmd_valid) else $error("read");
	cover property (reply_valid && !reply_error);
	cover property (reply_valid && reply_error);
	cover property (trouble_output && !servo_on_input);
endmodule : apsr_ctrl_properties
bind apsr_ctrl apsr_ctrl_properties u_apsr_ctrl_properties (.*);
`default_nettype wire

// ### tb/apsr_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
module apsr_drive_model #(
	parameter logic [7:0] STATION = 8'h05
) (
	input  wire logic        clock,
	input  wire logic        servo_on_input,
	input  wire logic        forced_stop_input,
	input  wire logic        trouble_output,
	input  wire logic        bad,
	input  wire logic        mute,
	input  wire logic [31:0] cur_pos,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_station,
	output logic             cmd_ready = 1'h0,
	output logic             ready_output,
	output logic             reply_valid = 1'h0,
	output logic             reply_error = 1'h0,
	output logic      [31:0] reply_pos = 32'h0,
	output logic      [31:0] pos_cmd = 32'h0
);
	int   on_cnt = 0;
	int   lat = 0;
	logic rel = 1'h0;
	logic good = 1'h0;
	// One cycle stands for 1 ms; stage 95 or 210, ready 5 later
	assign ready_output = on_cnt >= (rel ? 215 : 100);
	always @(posedge clock) begin
		on_cnt <= servo_on_input && !forced_stop_input && !trouble_output ? on_cnt + 1 : 0;
		rel <= forced_stop_input || (rel && servo_on_input);
		cmd_ready <= cmd_valid && !cmd_ready;
		reply_valid <= 1'h0;
		reply_pos <= ~reply_pos;
		lat <= lat > 0 ? lat - 1 : 0;
		if (cmd_valid && cmd_ready && cmd_station == STATION && !mute) begin
			lat <= 4;
			good <= !bad;
		end
		if (lat == 1) begin
			reply_valid <= 1'h1;
			reply_error <= !good;
			reply_pos <= good ? cur_pos : 32'h0;
			pos_cmd <= good ? cur_pos : pos_cmd;
		end
	end
endmodule : apsr_drive_model
`default_nettype wire

// ### tb/tb_abs_position_serial_readout.sv
`timescale 1ns/10ps
`default_nettype none
module tb_abs_position_serial_readout;
	logic        clock = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, bad = 1'h0, mute = 1'h1;
	logic        trouble_output = 1'h0, forced_stop_input = 1'h0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0, cur_pos = 32'h1234abcd, rdata, reply_pos, pos_cmd;
	logic [7:0]  cmd_station, cmd_code, cmd_data_no;
	logic        servo_on_input, alarm_reset_input, ready_output, cmd_valid, cmd_ready;
	logic        reply_valid, reply_error, pulse_enable, irq;
	int          err_count = 0, cmp_count = 0;
	apsr_ctrl #(.TIMEOUT_CYC(50)) u_apsr_ctrl (.*);
	apsr_drive_model u_apsr_drive_model (.*);
	initial forever #20 clock = ~clock;
	initial begin
		#200000;
		err_count++;
		stop_test;
	end
	task automatic stop_test;
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clock);
		wr <= 1'h0;
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'h1;
		@(posedge clock);
		rd <= 1'h0;
		@(negedge clock);
		chk(rdata & m, e);
	endtask : rd_chk
	task automatic wait_pe(input logic e);
		for (int i = 0; i < 900 && pulse_enable !== e; i++)
			@(negedge clock);
		chk(pulse_enable, e);
	endtask : wait_pe
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1'h1;
		rd_chk(4'h1, 32'h7f, 32'h1);
		rd_chk(4'hf, 32'hffffffff, 32'h0);
		wr_reg(4'h4, 32'h7);
		rd_chk(4'h4, 32'hffffffff, 32'h7);
		wr_reg(4'h0, 32'h501);
		rd_chk(4'h0, 32'hffffffff, 32'h501);
		for (int i = 0; i < 900 && (cmd_valid & cmd_ready) !== 1'h1; i++)
			@(negedge clock);
		@(posedge clock);
		mute <= 1'h0;
		repeat (40) @(negedge clock);
		chk(pulse_enable, 1'h0);
		wait_pe(1'h1);
		rd_chk(4'h2, 32'hffffffff, 32'h1234abcd);
		chk(pos_cmd, 32'h1234abcd);
		chk(irq, 1'h1);
		wr_reg(4'h5, 32'h7);
		forced_stop_input <= 1'h1;
		bad <= 1'h1;
		cur_pos <= 32'h80000001;
		wait_pe(1'h0);
		@(posedge clock);
		forced_stop_input <= 1'h0;
		for (int i = 0; i < 900 && irq !== 1'h1; i++)
			@(negedge clock);
		rd_chk(4'h1, 32'h00ff07ff, 32'h00040120);
		wr_reg(4'h0, 32'h500);
		bad <= 1'h0;
		wr_reg(4'h0, 32'h501);
		wait_pe(1'h1);
		rd_chk(4'h2, 32'hffffffff, 32'h80000001);
		@(posedge clock);
		trouble_output <= 1'h1;
		wait_pe(1'h0);
		rd_chk(4'h1, 32'h3ff, 32'h240);
		chk(servo_on_input, 1'h0);
		@(posedge clock);
		trouble_output <= 1'h0;
		wr_reg(4'h0, 32'h502);
		@(posedge clock);
		@(negedge clock);
		chk(alarm_reset_input, 1'h1);
		wr_reg(4'h0, 32'h501);
		wait_pe(1'h1);
		rd_chk(4'h3, 32'h5, 32'h5);
		stop_test;
	end
endmodule : tb_abs_position_serial_readout
`default_nettype wire
